// *** acs_far_model.sv ***
`timescale 1ns/1ps
module acs_far_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // commands from the bench
    input wire logic [7:0] event_i,
    input wire logic [7:0] ack_i,
    input wire logic [9:0] level_i,
    // towards the sequencer
    output logic [7:0] trig_src_o,
    output logic [9:0] data_o
);
    ////////////////////////////////////////////////////////////////////////////////
    // source flags latch on their event whatever the interrupt mask says
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_src_o <= 8'h00;
        end else begin
            trig_src_o <= (trig_src_o & ~ack_i) | event_i;
        end
    end
    // analog value passed straight through from level_i, with no hold during a conversion
    assign data_o = level_i;
endmodule : acs_far_model

// *** acs_pkg.sv ***
package acs_pkg;
    localparam int unsigned DATA_W = 10;
    localparam int unsigned CHAN_W = 5;
    localparam int unsigned TSEL_W = 3;
    localparam int unsigned PSEL_W = 3;
    localparam int unsigned PCNT_W = 7;
    localparam int unsigned CCNT_W = 5;
    localparam int unsigned TRIG_SYNC = 3;
    localparam logic [CCNT_W-1:0] NORM_CYCLES = 5'h0D;
    localparam logic [CCNT_W-1:0] FIRST_CYCLES = 5'h19;
    localparam logic [CCNT_W-1:0] SH_NORM = 5'h01;
    localparam logic [CCNT_W-1:0] SH_FIRST = 5'h0D;
    localparam logic [CCNT_W-1:0] SH_AUTO = 5'h02;
    localparam logic [TSEL_W-1:0] TSEL_FREE = 3'h0;
    localparam logic [CHAN_W-1:0] CHAN_DIFF_BASE = 5'h08;
    localparam logic [1:0] REF_EXT = 2'h0;
    localparam logic [1:0] REF_SUPPLY = 2'h1;
    localparam logic [1:0] REF_INT = 2'h3;
    localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
    localparam logic [1:0] REF_RST = 2'h0;
    typedef enum logic [1:0] {
        ACS_IDLE = 2'b00,
        ACS_WAIT = 2'b01,
        ACS_CONV = 2'b10
    } acs_state_t;
endpackage : acs_pkg

// *** acs_presc_if.sv ***
`timescale 1ns/1ps
interface acs_presc_if;
    logic enable;
    logic restart;
    logic [acs_pkg::PSEL_W-1:0] sel;
    logic tick;
    modport ctrl (output enable, output restart, output sel, input tick);
    modport div (input enable, input restart, input sel, output tick);
endinterface : acs_presc_if

// *** acs_prescaler.sv ***
`timescale 1ns/1ps
module acs_prescaler (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control from sequencer
    acs_presc_if.div pif
);
    import acs_pkg::*;

    logic [PCNT_W-1:0] cnt_q;
    logic [PCNT_W-1:0] last;

    // code 0 and 1 both divide by two; codes above divide by 2**code
    always_comb begin
        last = PCNT_W'(1);
        if (pif.sel > PSEL_W'(1)) begin
            last = PCNT_W'((1 << pif.sel) - 1);
        end
    end

    // compare with >= so a smaller divisor picked mid-count cannot leave the count stranded above it
    assign pif.tick = pif.enable && !pif.restart && (cnt_q >= last);

    // held at zero while disabled, restarted by a trigger
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_q <= '0;
        end else if (!pif.enable || pif.restart) begin
            cnt_q <= '0;
        end else if (cnt_q >= last) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + PCNT_W'(1);
        end
    end

    presc_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !pif.enable |=> cnt_q == '0)
        else $error("prescaler not held while disabled");

endmodule : acs_prescaler

// *** acs_sequencer.sv ***
`timescale 1ns/1ps
module acs_sequencer (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // control fields
    input wire logic enable_i,
    input wire logic start_wr_i,
    input wire logic auto_trigger_i,
    input wire logic [acs_pkg::TSEL_W-1:0] trigger_select_i,
    input wire logic [acs_pkg::PSEL_W-1:0] prescale_select_i,
    input wire logic left_align_i,
    input wire logic [acs_pkg::CHAN_W-1:0] channel_select_i,
    input wire logic [1:0] reference_select_i,
    // flag clearing and result reads
    input wire logic flag_clr_i,
    input wire logic irq_ack_i,
    input wire logic rd_low_i,
    input wire logic rd_high_i,
    // trigger sources, same clock; index 0 unused (own flag)
    input wire logic [(1<<acs_pkg::TSEL_W)-1:0] trig_src_i,
    // analog core
    input wire logic [acs_pkg::DATA_W-1:0] data_i,
    // status
    output logic start_bit_o,
    output logic flag_o,
    output logic [7:0] result_high_o,
    output logic [7:0] result_low_o,
    output logic locked_o,
    // analog front end steering
    output logic sample_o,
    output logic converting_o,
    output logic [acs_pkg::CHAN_W-1:0] chan_o,
    output logic gain_bypass_o,
    output logic ref_supply_o,
    output logic ref_internal_o
);
    import acs_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // prescaler
    acs_presc_if pif ();
    acs_prescaler u_presc (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .pif(pif)
    );

    acs_state_t state_q;
    acs_state_t state_d;
    logic [CCNT_W-1:0] cnt_q;
    logic [CCNT_W-1:0] cnt_d;
    logic first_q;
    logic auto_q;
    logic lock_q;
    logic trig_prev_q;
    logic [TRIG_SYNC-1:0] trig_pipe_q;
    logic trig_edge;
    logic trig_go;
    logic free_run;
    logic done;
    logic [CCNT_W-1:0] conv_len;
    logic [CCNT_W-1:0] sh_point;

    assign pif.enable = enable_i;
    assign pif.sel = prescale_select_i;
    assign pif.restart = trig_go && (state_q == ACS_IDLE);

    ////////////////////////////////////////////////////////////////////////////////
    // trigger edge detection and synchronisation delay
    assign free_run = auto_trigger_i && (trigger_select_i == TSEL_FREE);
    assign trig_edge = trig_src_i[trigger_select_i] && !trig_prev_q;
    assign trig_go = trig_pipe_q[TRIG_SYNC-1];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_prev_q <= 1'b0;
        end else begin
            trig_prev_q <= trig_src_i[trigger_select_i];
        end
    end

    // edges are only looked for when nothing runs; a level held through completion
    // gives no new edge, so it starts nothing
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            trig_pipe_q <= '0;
        end else begin
            trig_pipe_q <= {trig_pipe_q[TRIG_SYNC-2:0],
                trig_edge && auto_trigger_i && !free_run && enable_i
                && (state_q == ACS_IDLE)};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // conversion sequencing
    assign conv_len = first_q ? FIRST_CYCLES : NORM_CYCLES;
    assign sh_point = first_q ? SH_FIRST : (auto_q ? SH_AUTO : SH_NORM);
    assign done = (state_q == ACS_CONV) && pif.tick && (cnt_q == conv_len - CCNT_W'(1));

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ACS_IDLE: begin
                if (trig_go) begin
                    state_d = ACS_CONV;
                    cnt_d = '0;
                end else if (start_wr_i) begin
                    state_d = ACS_WAIT;
                end
            end
            ACS_WAIT: begin
                if (pif.tick) begin
                    state_d = ACS_CONV;
                    cnt_d = '0;
                end
            end
            ACS_CONV: begin
                if (done) begin
                    cnt_d = '0;
                    // own completion as source chains straight on, flag ignored
                    state_d = free_run ? ACS_CONV : ACS_IDLE;
                end else if (pif.tick) begin
                    cnt_d = cnt_q + CCNT_W'(1);
                end
            end
            default: begin
                state_d = ACS_IDLE;
            end
        endcase
        if (!enable_i) begin
            state_d = ACS_IDLE;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ACS_IDLE;
            cnt_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // first conversion after enabling is the long one
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            first_q <= 1'b1;
        end else if (!enable_i) begin
            first_q <= 1'b1;
        end else if (done) begin
            first_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            auto_q <= 1'b0;
        end else if (state_q == ACS_IDLE) begin
            auto_q <= trig_go;
        end else if (done) begin
            auto_q <= 1'b0;
        end
    end

    // start bit reads one for any running conversion
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_bit_o <= 1'b0;
            converting_o <= 1'b0;
        end else begin
            start_bit_o <= (state_d != ACS_IDLE);
            converting_o <= (state_d == ACS_CONV);
        end
    end

    // sample pulse; half-cycle points land on the preceding whole tick
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sample_o <= 1'b0;
        end else begin
            sample_o <= (state_q == ACS_CONV) && pif.tick
                && (cnt_q + CCNT_W'(1) == sh_point);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // front end selections: only while enabled and between conversions
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            chan_o <= CHAN_RST;
            gain_bypass_o <= 1'b1;
            ref_supply_o <= 1'b0;
            ref_internal_o <= 1'b0;
        end else if (enable_i && (state_q != ACS_CONV)) begin
            chan_o <= channel_select_i;
            gain_bypass_o <= (channel_select_i < CHAN_DIFF_BASE);
            ref_supply_o <= (reference_select_i == REF_SUPPLY);
            ref_internal_o <= (reference_select_i == REF_INT);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result registers and read lock
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lock_q <= 1'b0;
        end else if (rd_high_i) begin
            lock_q <= 1'b0;
        end else if (rd_low_i) begin
            lock_q <= 1'b1;
        end
    end

    assign locked_o = lock_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            result_high_o <= 8'h00;
            result_low_o <= 8'h00;
        end else if (done && !lock_q) begin
            if (left_align_i) begin
                result_high_o <= data_i[9:2];
                result_low_o <= {data_i[1:0], 6'h00};
            end else begin
                result_high_o <= {6'h00, data_i[9:8]};
                result_low_o <= data_i[7:0];
            end
        end
    end

    // flag sets on every completion, locked or not; set wins over clear
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            flag_o <= 1'b0;
        end else if (done) begin
            flag_o <= 1'b1;
        end else if (flag_clr_i || irq_ack_i) begin
            flag_o <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    lock_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done && lock_q |=> $stable(result_high_o) && $stable(result_low_o))
        else $error("result changed while locked");

    lock_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_low_i && !rd_high_i |=> locked_o)
        else $error("low read did not lock");

    unlock_read_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rd_high_i |=> !locked_o)
        else $error("high read did not unlock");

    flag_on_done_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done |=> flag_o)
        else $error("flag missing after completion");

    start_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done && !free_run && enable_i |=> !start_bit_o && flag_o)
        else $error("start bit not cleared at completion");

    free_chain_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done && free_run && enable_i |=> start_bit_o && converting_o)
        else $error("free running did not chain");

    chan_stable_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_q == ACS_CONV && state_d == ACS_CONV |=> $stable(chan_o))
        else $error("channel changed mid conversion");

    disabled_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !enable_i |=> state_q == ACS_IDLE && $stable(chan_o) && !start_bit_o)
        else $error("activity while disabled");

    conv_len_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done |-> cnt_q == (first_q ? 5'h18 : 5'h0C))
        else $error("wrong conversion length");

    left_align_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        done && !lock_q && left_align_i |=> result_high_o == $past(data_i[9:2]))
        else $error("left aligned result wrong");

    trig_start_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        trig_go && state_q == ACS_IDLE && enable_i |=> converting_o && cnt_q == 5'h00)
        else $error("trigger did not start conversion");

    start_accept_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        start_wr_i && enable_i && state_q == ACS_IDLE |=> start_bit_o)
        else $error("start write not accepted");

    wait_tick_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_q == ACS_WAIT && pif.tick && enable_i |=> converting_o && cnt_q == 5'h00)
        else $error("conversion did not begin on converter tick");

    flag_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (flag_clr_i || irq_ack_i) && !done |=> !flag_o)
        else $error("flag not cleared");

    idle_quiet_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        state_q == ACS_IDLE && !trig_go && !start_wr_i |=> !converting_o)
        else $error("conversion started without request");

endmodule : acs_sequencer

// *** adc_conversion_sequencer_test.sv ***
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
    import acs_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic en, st, au, la, fc, ia, rl, rh;
    logic [TSEL_W-1:0] ts;
    logic [PSEL_W-1:0] ps;
    logic [CHAN_W-1:0] ch, chan;
    logic [1:0] rs;
    logic [7:0] ev, ak, trig, res_high, res_low;
    logic [DATA_W-1:0] lv, data;
    logic start_bit, flag, locked, sample, converting, bypass, ref_sup, ref_int;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;
    always #10 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////////////////
    acs_sequencer dut (.clk_i(clk_i), .rstn_i(rstn_i), .enable_i(en), .start_wr_i(st),
        .auto_trigger_i(au), .trigger_select_i(ts), .prescale_select_i(ps),
        .left_align_i(la), .channel_select_i(ch), .reference_select_i(rs), .flag_clr_i(fc),
        .irq_ack_i(ia), .rd_low_i(rl), .rd_high_i(rh), .trig_src_i(trig), .data_i(data),
        .start_bit_o(start_bit), .flag_o(flag), .result_high_o(res_high),
        .result_low_o(res_low), .locked_o(locked), .sample_o(sample),
        .converting_o(converting), .chan_o(chan), .gain_bypass_o(bypass),
        .ref_supply_o(ref_sup), .ref_internal_o(ref_int));
    acs_far_model far (.clk_i(clk_i), .rstn_i(rstn_i), .event_i(ev), .ack_i(ak),
        .level_i(lv), .trig_src_o(trig), .data_o(data));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: bit got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit
    task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: value got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic pulse(ref logic s);
        @(negedge clk_i);
        s = 1'b1;
        @(negedge clk_i);
        s = 1'b0;
    endtask : pulse
    task automatic fire(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk_i);
        ak = a;
        ev = e;
        @(negedge clk_i);
        ak = 8'h00;
        ev = 8'h00;
    endtask : fire
    // bounded wait, returns clocks spent
    task automatic wait_flag(output int k);
        k = 0;
        while (flag !== 1'b1 && k < 300) begin
            @(negedge clk_i);
            k++;
        end
        chk_bit(flag, 1'b1);
    endtask : wait_flag
    // tick edges are not aligned to the start write, so allow one divisor of slack
    task automatic chk_len(input int k, input int ticks, input int div);
        chk_bit(k >= ticks * div - 1 && k <= ticks * div + div + 2, 1'b1);
    endtask : chk_len
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            $display("Error %0t: timeout", $time);
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {en, st, au, la, fc, ia, rl, rh} = 8'h00;
        ts = 3'h0;
        ps = 3'h1; // divide by 2: far above the analog limit, keeps the run short
        ch = 5'h03;
        rs = 2'h1;
        ev = 8'h00;
        ak = 8'h00;
        lv = 10'h2B5;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        rstn_i = 1'b1;
        @(negedge clk_i);
        chk_bit(start_bit, 1'b0);
        chk_bit(bypass, 1'b1);
        chk_val(chan, 10'h000);
        chk_bit(ref_sup, 1'b0);
        en = 1'b1;
        repeat (2) @(negedge clk_i);
        chk_val(chan, 10'h003);
        for (int r = 0; r < 4; r++) begin
            rs = r[1:0];
            repeat (2) @(negedge clk_i);
            chk_bit(ref_sup, r == 1);
            chk_bit(ref_int, r == 3);
        end
        ch = 5'h09;
        repeat (2) @(negedge clk_i);
        chk_bit(bypass, 1'b0);
        ch = 5'h03;
        pulse(st);
        chk_bit(start_bit, 1'b1);
        wait_flag(n);
        chk_len(n, 25, 2);
        chk_bit(start_bit, 1'b0);
        chk_val(res_high, 10'h002);
        chk_val(res_low, 10'h0B5);
        la = 1'b1;
        pulse(fc);
        chk_bit(flag, 1'b0);
        pulse(st);
        wait_flag(n);
        chk_len(n, 13, 2);
        chk_val(res_high, 10'h0AD);
        chk_val(res_low, 10'h040);
        pulse(rl);
        chk_bit(locked, 1'b1);
        lv = 10'h3C6;
        pulse(ia);
        chk_bit(flag, 1'b0);
        pulse(st);
        wait_flag(n);
        chk_val(res_high, 10'h0AD);
        chk_val(res_low, 10'h040);
        pulse(rh);
        chk_bit(locked, 1'b0);
        pulse(fc);
        pulse(st);
        repeat (6) @(negedge clk_i);
        ch = 5'h05;
        repeat (2) @(negedge clk_i);
        chk_val(chan, 10'h003);
        wait_flag(n);
        chk_val(res_high, 10'h0F1);
        chk_val(res_low, 10'h080);
        repeat (2) @(negedge clk_i);
        chk_val(chan, 10'h005);
        ps = 3'h2;
        pulse(fc);
        pulse(st);
        wait_flag(n);
        chk_len(n, 13, 4);
        ps = 3'h1;
        au = 1'b1;
        ts = 3'h2;
        pulse(fc);
        fire(8'h00, 8'h04);
        wait_flag(n);
        chk_bit(n >= 26 && n <= 36, 1'b1);
        pulse(fc);
        repeat (80) @(negedge clk_i);
        chk_bit(flag, 1'b0);
        fire(8'h04, 8'h00);
        fire(8'h00, 8'h04);
        repeat (8) @(negedge clk_i);
        chk_bit(start_bit, 1'b1);
        fire(8'h04, 8'h00);
        fire(8'h00, 8'h04);
        wait_flag(n);
        pulse(fc);
        repeat (80) @(negedge clk_i);
        chk_bit(flag, 1'b0);
        pulse(st);
        chk_bit(start_bit, 1'b1);
        wait_flag(n);
        ts = 3'h0;
        pulse(st);
        n = 0;
        repeat (120) begin
            @(negedge clk_i);
            n += int'(sample === 1'b1);
        end
        chk_bit(n >= 4 && n <= 5, 1'b1);
        chk_bit(start_bit, 1'b1);
        en = 1'b0;
        au = 1'b0;
        repeat (2) @(negedge clk_i);
        chk_bit(start_bit, 1'b0);
        chk_bit(converting, 1'b0);
        en = 1'b1;
        pulse(fc);
        pulse(st);
        wait_flag(n);
        chk_len(n, 25, 2);
        finish_test();
    end
endmodule : adc_conversion_sequencer_test
